// ===== include/xlsc_pkg.sv
package xlsc_pkg;

    // Register byte offsets
    localparam logic [11:0] XLSC_OFF_LINK_CTL   = 12'h000;
    localparam logic [11:0] XLSC_OFF_PHY_CFG0   = 12'h004;
    localparam logic [11:0] XLSC_OFF_PHY_STATE0 = 12'h008;
    localparam logic [11:0] XLSC_OFF_PORT_CFG   = 12'h00c;

    // link_control_reg fields
    localparam int XLSC_LINK_DIS_BIT = 4;
    localparam int XLSC_HOTRST_BIT   = 0;
    // phy_link_cfg_zero fields
    localparam int XLSC_COMPAT_BIT   = 0;
    // phy_link_state_zero fields
    localparam int XLSC_RETRAIN_BIT  = 0;
    localparam int XLSC_COMPACT_BIT  = 1;
    localparam int XLSC_STATE_LSB    = 4;
    localparam int XLSC_STATE_W      = 3;
    // port config fields
    localparam int XLSC_USP_BIT      = 0;
    localparam int XLSC_PDIS_BIT     = 1;
    localparam int XLSC_DNLANE_BIT   = 2;

    // Training set symbol 4 bits that legacy mode suppresses
    localparam int XLSC_TS_RATE_BIT  = 2;
    localparam int XLSC_TS_MULTI_BIT = 6;
    localparam int XLSC_TS_SPEED_BIT = 7;

    // Link training states
    typedef enum logic [2:0] {
        XLSC_DETECT,
        XLSC_TRAIN,
        XLSC_L0,
        XLSC_RECOVERY,
        XLSC_HOT_RESET,
        XLSC_DISABLED
    } xlsc_state_e;

    // Goal kept while passing through recovery
    typedef enum logic [1:0] {
        XLSC_GOAL_NONE,
        XLSC_GOAL_HOTRST,
        XLSC_GOAL_DISABLE,
        XLSC_GOAL_RETRAIN
    } xlsc_goal_e;

endpackage

// ===== rtl/xlsc_ts_mask.sv
`timescale 1ns/1ns
`default_nettype none
module xlsc_ts_mask
    import xlsc_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk_in,
    input  wire logic       srst_in,
    // Symbol 4 in and out
    input  wire logic       legacy_in,
    input  wire logic [7:0] sym4_in,
    output logic      [7:0] sym4_out
);

    logic [7:0] sym4_r;
    logic [7:0] sym4_nxt;
    logic [7:0] keep;

    always_comb begin
        keep = 8'hff;
        if (legacy_in) begin
            keep[XLSC_TS_RATE_BIT]  = 1'b0;
            keep[XLSC_TS_MULTI_BIT] = 1'b0;
            keep[XLSC_TS_SPEED_BIT] = 1'b0;
        end
        sym4_nxt = sym4_in & keep;
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            sym4_r <= 8'h00;
        end else begin
            sym4_r <= sym4_nxt;
        end
    end

    assign sym4_out = sym4_r;

    a_ts_bits_clear: assert property (@(posedge mclk_in) disable iff (srst_in)
        legacy_in |=> (sym4_out[XLSC_TS_RATE_BIT] == 1'b0 && sym4_out[XLSC_TS_MULTI_BIT] == 1'b0
                      && sym4_out[XLSC_TS_SPEED_BIT] == 1'b0))
        else $error("suppressed training set bit sent in legacy mode");

    a_ts_bits_pass: assert property (@(posedge mclk_in) disable iff (srst_in)
        !legacy_in |=> sym4_out == $past(sym4_in))
        else $error("training set symbol altered outside legacy mode");

endmodule
`default_nettype wire

// ===== rtl/xlsc_crosslink_ctl.sv
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Upstream switch port ignores any higher-layer hot reset request.
// - Upstream switch port enters hot reset on received hot reset training sets.
// - Downstream switch port link disable request goes recovery, then disabled.
// - Downstream switch port enters disabled on received disabled training sets.
// - Upstream switch port ignores higher-layer link disable request in L0; a set request still blocks exit from disabled.
// - Upstream switch port enters disabled on received disabled training sets.
// - Port in disabled operating mode goes straight to detect, never disabled.
// - In legacy mode symbol 4 bits 2, 6, 7 of TS1/TS2 never set.
// - Clearing compat enable plus full retrain leaves legacy mode.
// - Downstream port with downstream lanes: higher hot reset goes recovery, hot reset.
// - Received hot reset in downstream port leaves config registers untouched.
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ns
`default_nettype none
module xlsc_crosslink_ctl
    import xlsc_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk_in,
    input  wire logic        srst_in,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Link events from the training logic
    input  wire logic        rx_ts_hotrst_in,
    input  wire logic        rx_ts_disable_in,
    input  wire logic        link_up_in,
    input  wire logic        recovery_done_in,
    input  wire logic        state_exit_in,
    // Transmit training set symbol 4
    input  wire logic [7:0]  tx_sym4_in,
    output logic      [7:0]  tx_sym4_out,
    // Link state and reset scope
    output logic      [2:0]  link_state_out,
    output logic             legacy_mode_out,
    output logic             port_reset_out
);

    //////////////////////////////////////////////////////////////////////////
    // Register file
    logic        link_dis_req_r, link_dis_req_nxt;
    logic        hotrq_r, hotrq_nxt;
    logic        compat_en_r, compat_en_nxt;
    logic [2:0]  pcfg_r, pcfg_nxt;
    logic        legacy_r, legacy_nxt;
    logic        retrain_r, retrain_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic        wr_en, rd_en, hit;
    xlsc_state_e state_r, state_nxt;
    xlsc_goal_e  goal_r, goal_nxt;
    logic        usp, pdis, dnlane;

    assign usp    = pcfg_r[XLSC_USP_BIT];
    assign pdis   = pcfg_r[XLSC_PDIS_BIT];
    assign dnlane = pcfg_r[XLSC_DNLANE_BIT];
    assign wr_en  = psel && penable && pwrite;
    assign rd_en  = psel && !penable && !pwrite;
    assign hit    = paddr == XLSC_OFF_LINK_CTL || paddr == XLSC_OFF_PHY_CFG0
                  || paddr == XLSC_OFF_PHY_STATE0 || paddr == XLSC_OFF_PORT_CFG;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit;

    always_comb begin
        link_dis_req_nxt = link_dis_req_r;
        hotrq_nxt     = 1'b0;
        compat_en_nxt = compat_en_r;
        pcfg_nxt      = pcfg_r;
        retrain_nxt   = 1'b0;
        prdata_nxt    = prdata_r;
        if (wr_en) begin
            unique case (paddr)
                XLSC_OFF_LINK_CTL: begin
                    link_dis_req_nxt = pwdata[XLSC_LINK_DIS_BIT];
                    hotrq_nxt = pwdata[XLSC_HOTRST_BIT];
                end
                XLSC_OFF_PHY_CFG0: begin
                    compat_en_nxt = pwdata[XLSC_COMPAT_BIT];
                end
                XLSC_OFF_PHY_STATE0: begin
                    retrain_nxt = pwdata[XLSC_RETRAIN_BIT];
                end
                XLSC_OFF_PORT_CFG: begin
                    pcfg_nxt = pwdata[XLSC_DNLANE_BIT:XLSC_USP_BIT];
                end
                default: begin
                end
            endcase
        end
        if (rd_en) begin
            prdata_nxt = 32'h0000_0000;
            unique case (paddr)
                XLSC_OFF_LINK_CTL: begin
                    prdata_nxt[XLSC_LINK_DIS_BIT] = link_dis_req_r;
                end
                XLSC_OFF_PHY_CFG0: begin
                    prdata_nxt[XLSC_COMPAT_BIT] = compat_en_r;
                end
                XLSC_OFF_PHY_STATE0: begin
                    prdata_nxt[XLSC_COMPACT_BIT] = legacy_r;
                    prdata_nxt[XLSC_STATE_LSB +: XLSC_STATE_W] = state_r;
                end
                XLSC_OFF_PORT_CFG: begin
                    prdata_nxt[XLSC_DNLANE_BIT:XLSC_USP_BIT] = pcfg_r;
                end
                default: begin
                end
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Link state machine
    always_comb begin
        state_nxt  = state_r;
        goal_nxt   = goal_r;
        legacy_nxt = legacy_r;
        unique case (state_r)
            XLSC_DETECT: begin
                if (!pdis) begin
                    state_nxt = XLSC_TRAIN;
                end
            end
            XLSC_TRAIN: begin
                if (link_up_in) begin
                    state_nxt = XLSC_L0;
                end
            end
            XLSC_L0: begin
                if (rx_ts_hotrst_in) begin
                    state_nxt = XLSC_HOT_RESET;
                end else if (rx_ts_disable_in) begin
                    state_nxt = XLSC_DISABLED;
                end else if (!usp && link_dis_req_r) begin
                    state_nxt = XLSC_RECOVERY;
                    goal_nxt  = XLSC_GOAL_DISABLE;
                end else if (!usp && dnlane && hotrq_r) begin
                    state_nxt = XLSC_RECOVERY;
                    goal_nxt  = XLSC_GOAL_HOTRST;
                end
            end
            XLSC_RECOVERY: begin
                if (recovery_done_in) begin
                    unique case (goal_r)
                        XLSC_GOAL_HOTRST:  state_nxt = XLSC_HOT_RESET;
                        XLSC_GOAL_DISABLE: state_nxt = XLSC_DISABLED;
                        XLSC_GOAL_RETRAIN: state_nxt = XLSC_DETECT;
                        XLSC_GOAL_NONE:    state_nxt = XLSC_L0;
                    endcase
                    goal_nxt = XLSC_GOAL_NONE;
                end
            end
            XLSC_HOT_RESET: begin
                if (state_exit_in) begin
                    state_nxt = XLSC_DETECT;
                end
            end
            XLSC_DISABLED: begin
                if (state_exit_in && !link_dis_req_r) begin
                    state_nxt = XLSC_DETECT;
                end
            end
        endcase
        if (retrain_r) begin
            state_nxt  = XLSC_DETECT;
            goal_nxt   = XLSC_GOAL_NONE;
            legacy_nxt = compat_en_r;
        end
        if (pdis) begin
            state_nxt = XLSC_DETECT;
            goal_nxt  = XLSC_GOAL_NONE;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            link_dis_req_r <= 1'b0;
            hotrq_r     <= 1'b0;
            compat_en_r <= 1'b0;
            pcfg_r      <= 3'h0;
            retrain_r   <= 1'b0;
            prdata_r    <= 32'h0000_0000;
            legacy_r    <= 1'b0;
            state_r     <= XLSC_DETECT;
            goal_r      <= XLSC_GOAL_NONE;
        end else begin
            link_dis_req_r <= link_dis_req_nxt;
            hotrq_r     <= hotrq_nxt;
            compat_en_r <= compat_en_nxt;
            pcfg_r      <= pcfg_nxt;
            retrain_r   <= retrain_nxt;
            prdata_r    <= prdata_nxt;
            legacy_r    <= legacy_nxt;
            state_r     <= state_nxt;
            goal_r      <= goal_nxt;
        end
    end

    assign prdata          = prdata_r;
    assign link_state_out  = state_r;
    assign legacy_mode_out = legacy_r;
    // Hot reset only resets the partition when the port is upstream
    assign port_reset_out  = usp && state_r == XLSC_HOT_RESET;

    xlsc_ts_mask xlsc_ts_mask_i (
        .mclk_in   (mclk_in),
        .srst_in   (srst_in),
        .legacy_in (legacy_r),
        .sym4_in   (tx_sym4_in),
        .sym4_out  (tx_sym4_out)
    );

    //////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_link_dis_l0;
        state_r == XLSC_L0 && !usp && link_dis_req_r && !rx_ts_hotrst_in && !rx_ts_disable_in
            && !retrain_r && !pdis;
    endsequence

    a_usp_no_hotrq: assert property (@(posedge mclk_in) disable iff (srst_in)
        (state_r == XLSC_L0 && usp && !rx_ts_hotrst_in && !rx_ts_disable_in)
            |=> state_r != XLSC_RECOVERY)
        else $error("upstream port acted on higher-layer request");
    a_rx_hotrst: assert property (@(posedge mclk_in) disable iff (srst_in)
        (state_r == XLSC_L0 && rx_ts_hotrst_in && !retrain_r && !pdis)
            |=> state_r == XLSC_HOT_RESET)
        else $error("received hot reset not taken");
    a_link_dis_path: assert property (@(posedge mclk_in) disable iff (srst_in)
        s_link_dis_l0 |=> state_r == XLSC_RECOVERY && goal_r == XLSC_GOAL_DISABLE)
        else $error("link disable did not pass through recovery");
    a_rx_disable: assert property (@(posedge mclk_in) disable iff (srst_in)
        (state_r == XLSC_L0 && rx_ts_disable_in && !rx_ts_hotrst_in && !retrain_r && !pdis)
            |=> state_r == XLSC_DISABLED)
        else $error("received disable not taken");
    a_pdis_detect: assert property (@(posedge mclk_in) disable iff (srst_in)
        pdis |=> state_r == XLSC_DETECT)
        else $error("disabled port left detect");
    a_legacy_follow: assert property (@(posedge mclk_in) disable iff (srst_in)
        retrain_r |=> legacy_r == $past(compat_en_r))
        else $error("legacy mode not updated on retrain");
    a_legacy_hold: assert property (@(posedge mclk_in) disable iff (srst_in)
        !retrain_r |=> $stable(legacy_r))
        else $error("legacy mode changed without retrain");
    a_hotrq_path: assert property (@(posedge mclk_in) disable iff (srst_in)
        (state_r == XLSC_RECOVERY && goal_r == XLSC_GOAL_HOTRST && recovery_done_in
            && !retrain_r && !pdis) |=> state_r == XLSC_HOT_RESET)
        else $error("directed hot reset did not follow recovery");
    a_dsp_no_reset: assert property (@(posedge mclk_in) disable iff (srst_in)
        !usp |-> !port_reset_out)
        else $error("downstream port reset its configuration");

endmodule
`default_nettype wire

// ===== verification/xlsc_link_partner.sv
`timescale 1ns/1ns
`default_nettype none
module xlsc_link_partner
    import xlsc_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk_in,
    input  wire logic       srst_in,
    // Commands from the bench
    input  wire logic       send_hotrst_in,
    input  wire logic       send_disable_in,
    input  wire logic       slow_in,
    // Observed link state
    input  wire logic [2:0] link_state_in,
    // Link events towards the port
    output logic            rx_ts_hotrst_out,
    output logic            rx_ts_disable_out,
    output logic            link_up_out,
    output logic            recovery_done_out,
    output logic            state_exit_out
);
    logic [2:0] prev_r;
    logic [3:0] cnt_r;
    logic [3:0] wait_cyc;

    always_ff @(posedge mclk_in) begin
        prev_r            <= link_state_in;
        rx_ts_hotrst_out  <= send_hotrst_in & ~srst_in;
        rx_ts_disable_out <= send_disable_in & ~srst_in;
        if (srst_in || prev_r != link_state_in) begin
            cnt_r <= 4'h0;
        end else if (cnt_r != 4'hf) begin
            cnt_r <= cnt_r + 4'h1;
        end
    end

    // Answer promptly or after a stall; link up and recovery done once per state visit, state exit held high from then on
    assign wait_cyc          = slow_in ? 4'h8 : 4'h1;
    assign link_up_out       = link_state_in == XLSC_TRAIN && cnt_r == wait_cyc;
    assign recovery_done_out = link_state_in == XLSC_RECOVERY && cnt_r == wait_cyc;
    assign state_exit_out    = (link_state_in == XLSC_HOT_RESET
                               || link_state_in == XLSC_DISABLED) && cnt_r >= wait_cyc;
endmodule
`default_nettype wire

// ===== verification/xlsc_crosslink_ctl_bench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(got_v, exp_v) begin check_count++; if ((got_v) !== (exp_v)) begin num_errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, (got_v), (exp_v)); end end
module xlsc_crosslink_ctl_bench
    import xlsc_pkg::*;
;
    logic mclk_in = 0, srst_in = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, e, hot = 0, dis = 0, slow = 0;
    logic rx_hot, rx_dis, lup, rdone, sexit, legacy, prst;
    logic [7:0] sym_in = 8'hff, sym_out;
    logic [2:0] st;
    int num_errors = 0, check_count = 0, cyc = 0;

    xlsc_crosslink_ctl xlsc_crosslink_ctl_i (.mclk_in(mclk_in), .srst_in(srst_in),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_ts_hotrst_in(rx_hot),
        .rx_ts_disable_in(rx_dis), .link_up_in(lup), .recovery_done_in(rdone),
        .state_exit_in(sexit), .tx_sym4_in(sym_in), .tx_sym4_out(sym_out),
        .link_state_out(st), .legacy_mode_out(legacy), .port_reset_out(prst));
    xlsc_link_partner xlsc_link_partner_i (.mclk_in(mclk_in), .srst_in(srst_in),
        .send_hotrst_in(hot), .send_disable_in(dis), .slow_in(slow), .link_state_in(st),
        .rx_ts_hotrst_out(rx_hot), .rx_ts_disable_out(rx_dis), .link_up_out(lup),
        .recovery_done_out(rdone), .state_exit_out(sexit));

    always #2 mclk_in = ~mclk_in;

    ////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge mclk_in) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            test_done();
        end
    end

    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge mclk_in);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge mclk_in);
        penable <= 1;
        @(posedge mclk_in);
        while (pready !== 1'b1) @(posedge mclk_in);
        q = prdata;
        e = pslverr;
        psel <= 0; penable <= 0;
    endtask

    task automatic wait_st(input logic [2:0] s);
        int n;
        n = 0;
        @(negedge mclk_in);
        while (st !== s && n < 200) begin
            n++;
            @(negedge mclk_in);
        end
        `CHK(st, s)
    endtask

    task automatic send(input logic h, input logic d);
        @(posedge mclk_in);
        hot <= h; dis <= d;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        `CHK({st, legacy, prst}, 5'h00)
        for (int i = 0; i < 16; i += 4) begin
            if (i != 8) begin
                apb(i[11:0], 0, 32'h0);
                `CHK({e, q}, 33'h0)
            end
        end
        apb(12'h010, 1, 32'hffffffff);
        `CHK(e, 1'b1)
        apb(12'h010, 0, 32'h0);
        `CHK({e, q}, 33'h100000000)
    endtask

    task automatic t_usp();
        slow <= 1;
        apb(XLSC_OFF_PORT_CFG, 1, 32'h1);
        wait_st(XLSC_L0);
        apb(XLSC_OFF_LINK_CTL, 1, 32'h1);
        repeat (12) @(negedge mclk_in);
        `CHK(st, XLSC_L0)
        apb(XLSC_OFF_LINK_CTL, 1, 32'h10);
        repeat (12) @(negedge mclk_in);
        `CHK(st, XLSC_L0)
        apb(XLSC_OFF_LINK_CTL, 0, 32'h0);
        `CHK(q, 32'h10)
        apb(XLSC_OFF_LINK_CTL, 1, 32'h0);
        send(1, 0);
        wait_st(XLSC_HOT_RESET);
        `CHK(prst, 1'b1)
        send(0, 0);
        wait_st(XLSC_L0);
        send(0, 1);
        wait_st(XLSC_DISABLED);
        send(0, 0);
        wait_st(XLSC_L0);
        slow <= 0;
    endtask

    task automatic t_dsp();
        apb(XLSC_OFF_PORT_CFG, 1, 32'h4);
        wait_st(XLSC_L0);
        apb(XLSC_OFF_LINK_CTL, 1, 32'h1);
        wait_st(XLSC_RECOVERY);
        wait_st(XLSC_HOT_RESET);
        wait_st(XLSC_L0);
        apb(XLSC_OFF_LINK_CTL, 1, 32'h10);
        wait_st(XLSC_RECOVERY);
        wait_st(XLSC_DISABLED);
        apb(XLSC_OFF_LINK_CTL, 1, 32'h0);
        wait_st(XLSC_L0);
        send(0, 1);
        wait_st(XLSC_DISABLED);
        send(1, 0);
        wait_st(XLSC_HOT_RESET);
        `CHK(prst, 1'b0)
        send(0, 0);
        wait_st(XLSC_L0);
        apb(XLSC_OFF_PORT_CFG, 0, 32'h0);
        `CHK(q, 32'h4)
    endtask

    task automatic t_pdis();
        apb(XLSC_OFF_PORT_CFG, 1, 32'h2);
        send(0, 1);
        repeat (12) @(negedge mclk_in);
        `CHK(st, XLSC_DETECT)
        send(0, 0);
        apb(XLSC_OFF_PORT_CFG, 1, 32'h0);
        wait_st(XLSC_L0);
        // Downstream port with upstream lanes: directed hot reset has no effect
        apb(XLSC_OFF_LINK_CTL, 1, 32'h1);
        repeat (12) @(negedge mclk_in);
        `CHK(st, XLSC_L0)
        // Link disable still passes through recovery with upstream lanes
        apb(XLSC_OFF_LINK_CTL, 1, 32'h10);
        wait_st(XLSC_RECOVERY);
        wait_st(XLSC_DISABLED);
        apb(XLSC_OFF_LINK_CTL, 1, 32'h0);
        wait_st(XLSC_L0);
    endtask

    task automatic t_legacy();
        apb(XLSC_OFF_PHY_CFG0, 1, 32'h1);
        apb(XLSC_OFF_PHY_STATE0, 1, 32'h1);
        // The link is still in L0 right after the retrain write
        wait_st(XLSC_TRAIN);
        wait_st(XLSC_L0);
        `CHK(legacy, 1'b1)
        `CHK(sym_out, 8'h3b)
        apb(XLSC_OFF_PHY_STATE0, 0, 32'h0);
        `CHK(q[XLSC_COMPACT_BIT], 1'b1)
        apb(XLSC_OFF_PHY_CFG0, 1, 32'h0);
        apb(XLSC_OFF_PHY_STATE0, 1, 32'h1);
        wait_st(XLSC_TRAIN);
        wait_st(XLSC_L0);
        `CHK(legacy, 1'b0)
        `CHK(sym_out, 8'hff)
    endtask

    initial begin
        repeat (6) @(posedge mclk_in);
        srst_in <= 0;
        @(negedge mclk_in);
        t_reset();
        t_usp();
        t_dsp();
        t_pdis();
        t_legacy();
        test_done();
    end
endmodule
`default_nettype wire
